// ---- rtl/stl_decoder.sv ----
// Execution of skip-if-carry, skip-if-port-bit and timer load instructions
// ==========================================================
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module stl_decoder (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// Sequencer side
	input  wire logic                   instrValid,
	input  wire stl_pkg::stl_instr_type instr,
	input  wire logic                   carryFlag,
	input  wire logic [7:0]             ledPort,
	output logic                        skipNext,
	output logic                        secondWord,
	// Timer side
	output logic                        timerOneLoad,
	output logic                        timerTwoLoad,
	output stl_pkg::stl_timer_type      timerOne,
	output stl_pkg::stl_timer_type      timerTwo,
	// AXI4-Lite slave
	input  wire logic [31:0]            awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	input  wire logic [31:0]            araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready
);
	import stl_pkg::*;

	stl_state_type state;
	stl_state_type next_state;
	logic          enable;
	logic          next_enable;
	logic          yError;
	logic          next_yError;
	logic          next_skipNext;
	logic          next_timerOneLoad;
	logic          next_timerTwoLoad;
	stl_timer_type next_timerOne;
	stl_timer_type next_timerTwo;
	logic [1:0]    next_bresp;
	logic          next_bvalid;
	logic [31:0]   next_rdata;
	logic [1:0]    next_rresp;
	logic          next_rvalid;
	logic          wrFire;
	logic          exec;
	logic [7:0]    nibbles;
	logic          yRangeHit;

	// ==========================================================
	// Bus handshakes: both write channels are taken together, and only
	// while no response is pending, so one write is in flight at a time
	assign wrFire     = awvalid && wvalid && !bvalid;
	assign awready    = wrFire;
	assign wready     = wrFire;
	assign arready    = !rvalid;
	assign secondWord = (state == ST_SECOND);
	assign exec       = instrValid && enable;
	assign nibbles    = {instr.regB, instr.accA};
	assign yRangeHit  = exec && (state == ST_SECOND) &&
		(instr.code == OP_SKIP_PORT_2) && (instr.regY > Y_MAX);

	// ==========================================================
	// Next values for decoder and register file
	always_comb
	begin
		next_state        = state;
		next_enable       = enable;
		next_yError       = yError;
		next_skipNext     = 1'b0;
		next_timerOneLoad = 1'b0;
		next_timerTwoLoad = 1'b0;
		next_timerOne     = timerOne;
		next_timerTwo     = timerTwo;
		next_bresp        = bresp;
		next_bvalid       = bvalid;
		next_rdata        = rdata;
		next_rresp        = rresp;
		next_rvalid       = rvalid;
		// Carry is only read here, never written, so it stays unchanged
		if (exec)
		begin
			case (state)
				ST_IDLE:
				begin
					case (instr.code)
						OP_SKIP_CARRY:
							next_skipNext = !carryFlag;
						OP_SKIP_PORT_1:
							next_state = ST_SECOND;
						OP_LOAD_T1:
						begin
							next_timerOne     = '{reload: nibbles,
								value: nibbles};
							next_timerOneLoad = 1'b1;
						end
						OP_LOAD_T2:
						begin
							next_timerTwo     = '{reload: nibbles,
								value: nibbles};
							next_timerTwoLoad = 1'b1;
						end
						default:
							next_skipNext = 1'b0;
					endcase
				end
				ST_SECOND:
				begin
					// A wrong second word abandons the test without skipping
					next_state = ST_IDLE;
					if (instr.code == OP_SKIP_PORT_2)
					begin
						// Y above 7 is out of range: never skip
						next_skipNext = (instr.regY <= Y_MAX) &&
							!ledPort[instr.regY[2:0]];
					end
				end
				default:
					next_state = ST_IDLE;
			endcase
		end
		// Write channel: the control register is writable, and a status write can clear the range error
		if (bvalid && bready)
			next_bvalid = 1'b0;
		if (wrFire)
		begin
			next_bvalid = 1'b1;
			next_bresp  = RESP_SLVERR;
			if (awaddr[7:0] == OFS_CTRL && awaddr[31:8] == 24'h000000)
			begin
				next_bresp = RESP_OKAY;
				if (wstrb[0])
					next_enable = wdata[CTRL_EN_BIT];
			end
			else if (awaddr[7:0] == OFS_STATUS &&
				awaddr[31:8] == 24'h000000)
			begin
				// Writing status with bit 1 set clears the sticky range error
				next_bresp = RESP_OKAY;
				if (wstrb[0] && wdata[1])
					next_yError = 1'b0;
			end
		end
		// Range error is sticky and beats a clear landing in the same cycle
		if (yRangeHit)
			next_yError = 1'b1;
		// Read channel
		if (rvalid && rready)
			next_rvalid = 1'b0;
		if (arvalid && arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			next_rdata  = 32'h00000000;
			if (araddr[31:8] != 24'h000000)
				next_rresp = RESP_SLVERR;
			else
			begin
				case (araddr[7:0])
					OFS_CTRL:      next_rdata = {31'h00000000, enable};
					OFS_STATUS:    next_rdata = {29'h00000000, skipNext,
						yError, secondWord};
					OFS_TIMER_ONE: next_rdata = {16'h0000, timerOne};
					OFS_TIMER_TWO: next_rdata = {16'h0000, timerTwo};
					default:       next_rresp = RESP_SLVERR;
				endcase
			end
		end
	end

	// ==========================================================
	// State registers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state        <= ST_IDLE;
			enable       <= RST_ENABLE;
			yError       <= 1'b0;
			skipNext     <= 1'b0;
			timerOneLoad <= 1'b0;
			timerTwoLoad <= 1'b0;
			timerOne     <= '0;
			timerTwo     <= '0;
			bresp        <= RESP_OKAY;
			bvalid       <= 1'b0;
			rdata        <= 32'h00000000;
			rresp        <= RESP_OKAY;
			rvalid       <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			enable       <= next_enable;
			yError       <= next_yError;
			skipNext     <= next_skipNext;
			timerOneLoad <= next_timerOneLoad;
			timerTwoLoad <= next_timerTwoLoad;
			timerOne     <= next_timerOne;
			timerTwo     <= next_timerTwo;
			bresp        <= next_bresp;
			bvalid       <= next_bvalid;
			rdata        <= next_rdata;
			rresp        <= next_rresp;
			rvalid       <= next_rvalid;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_carry_skip;
		exec && state == ST_IDLE && instr.code == OP_SKIP_CARRY &&
			!carryFlag |=> skipNext;
	endproperty
	a_carry_skip: assert property (p_carry_skip)
		else $error("carry clear did not skip");

	property p_carry_noskip;
		exec && state == ST_IDLE && instr.code == OP_SKIP_CARRY &&
			carryFlag |=> !skipNext && state == ST_IDLE;
	endproperty
	a_carry_noskip: assert property (p_carry_noskip)
		else $error("carry set caused a skip");

	property p_index_range;
		skipNext && $past(state) == ST_SECOND |-> $past(instr.regY) <= Y_MAX;
	endproperty
	a_index_range: assert property (p_index_range)
		else $error("port skip taken with index above 7");

	property p_port_skip;
		exec && state == ST_SECOND && instr.code == OP_SKIP_PORT_2 &&
			instr.regY <= Y_MAX && !ledPort[instr.regY[2:0]]
			|=> skipNext && state == ST_IDLE;
	endproperty
	a_port_skip: assert property (p_port_skip)
		else $error("port bit clear did not skip");

	property p_port_noskip;
		exec && state == ST_SECOND && ledPort[instr.regY[2:0]] |=> !skipNext;
	endproperty
	a_port_noskip: assert property (p_port_noskip)
		else $error("port bit set caused a skip");

	property p_load_one;
		exec && state == ST_IDLE && instr.code == OP_LOAD_T1 |=>
			timerOneLoad && timerOne.value[7:4] == $past(instr.regB) &&
			timerOne.value[3:0] == $past(instr.accA) &&
			timerOne.reload == timerOne.value;
	endproperty
	a_load_one: assert property (p_load_one)
		else $error("timer one load wrong");

	property p_load_two;
		exec && state == ST_IDLE && instr.code == OP_LOAD_T2 |=>
			timerTwoLoad && timerTwo.reload[7:4] == $past(instr.regB) &&
			timerTwo.reload[3:0] == $past(instr.accA) &&
			timerTwo.value == timerTwo.reload && !timerOneLoad;
	endproperty
	a_load_two: assert property (p_load_two)
		else $error("timer two load wrong");

	property p_two_words;
		exec && state == ST_IDLE && instr.code == OP_SKIP_PORT_1 |=>
			(secondWord && !skipNext) and (exec |=> !secondWord);
	endproperty
	a_two_words: assert property (p_two_words)
		else $error("port skip did not span two words");

	c_carry_skip: cover property (skipNext && $past(state) == ST_IDLE);
	c_port_skip: cover property (secondWord ##1 skipNext);
	c_both_loads: cover property (timerOneLoad ##[1:20] timerTwoLoad);
endmodule
`default_nettype wire

// ---- common/stl_pkg.sv ----
// Shared constants and carrier types for the skip and timer-load decoder
`default_nettype none
package stl_pkg;
	// ==========================================================
	// Instruction codes
	localparam logic [9:0] OP_SKIP_CARRY  = 10'h02F;
	localparam logic [9:0] OP_SKIP_PORT_1 = 10'h024;
	localparam logic [9:0] OP_SKIP_PORT_2 = 10'h02B;
	localparam logic [9:0] OP_LOAD_T1     = 10'h230;
	localparam logic [9:0] OP_LOAD_T2     = 10'h231;
	// Highest legal index register value
	localparam logic [3:0] Y_MAX          = 4'h7;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_STATUS     = 8'h04;
	localparam logic [7:0] OFS_TIMER_ONE  = 8'h08;
	localparam logic [7:0] OFS_TIMER_TWO  = 8'h0C;
	// Reset values and fields
	localparam logic       RST_ENABLE     = 1'h1;
	localparam int         CTRL_EN_BIT    = 0;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	// ==========================================================
	// Instruction word with its operands, as the sequencer offers it
	typedef struct packed {
		logic [9:0] code;
		logic [3:0] accA;
		logic [3:0] regB;
		logic [3:0] regY;
	} stl_instr_type;
	// Timer counter and its reload register
	typedef struct packed {
		logic [7:0] reload;
		logic [7:0] value;
	} stl_timer_type;
	typedef enum logic [0:0] {
		ST_IDLE   = 1'b0,
		ST_SECOND = 1'b1
	} stl_state_type;
endpackage
`default_nettype wire

// ---- bench/stl_decoder_test.sv ----
// Self-checking bench for the skip and timer-load decoder
`timescale 1ns/1ps
`default_nettype none
module stl_decoder_test;
	import stl_pkg::*;
	// ==========================================================
	// Stimulus and observed signals
	logic          clk = 1'b0;
	logic          arst_n = 1'b0;
	logic          instrValid = 1'b0;
	stl_instr_type instr = '0;
	logic          carryFlag = 1'b0;
	logic [7:0]    ledPort = 8'h00;
	logic          skipNext, secondWord, timerOneLoad, timerTwoLoad;
	stl_timer_type timerOne, timerTwo;
	logic [31:0]   awaddr = '0, wdata = '0, araddr = '0, rdata, rd;
	logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic          arvalid = 1'b0, rready = 1'b0;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [1:0]    bresp, rresp, rsp;
	int            n_mismatch = 0;
	int            total_checks = 0;

	// ==========================================================
	// Design; all strobes of a write are always enabled
	stl_decoder DUT (
		.clk, .arst_n, .instrValid, .instr, .carryFlag, .ledPort,
		.skipNext, .secondWord, .timerOneLoad, .timerTwoLoad,
		.timerOne, .timerTwo, .awaddr, .awvalid, .awready, .wdata,
		.wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
	);

	// 100 ns period
	always #50 clk = ~clk;

	// ==========================================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Offer one word; the #1 lets the edge's register updates land
	task automatic send(input logic [9:0] c, input logic [3:0] a, b, y);
		@(posedge clk);
		instrValid <= 1'b1;
		instr <= '{code: c, accA: a, regB: b, regY: y};
		#1;
	endtask

	task automatic idle;
		@(posedge clk);
		instrValid <= 1'b0;
		#1;
	endtask

	// Address and data offered together, held until taken
	task automatic axiWr(input logic [31:0] a, d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge clk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axiRd(input logic [31:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==========================================================
	// Watchdog: the sequence needs well under 2000 cycles
	initial
	begin
		#(2000 * 100);
		n_mismatch++;
		results();
	end

	// ==========================================================
	// Test sequence
	initial
	begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		axiRd(OFS_CTRL);
		chk("ctrl reset", rd, 32'h1);
		axiRd(OFS_STATUS);
		chk("status reset", rd, 32'h0);
		axiRd(32'h10);
		chk("unmapped read", rsp, RESP_SLVERR);
		chk("unmapped read data", rd, 32'h0);
		axiWr(32'h20, 32'h0);
		chk("unmapped write", rsp, RESP_SLVERR);
		$display("test registers done");
		// Carry skip for both flag values
		for (int c = 0; c < 2; c++)
		begin
			carryFlag <= c[0];
			send(OP_SKIP_CARRY, 4'h0, 4'h0, 4'h0);
			idle();
			chk("carry skip", skipNext, !c[0]);
		end
		$display("test carry skip done");
		// Every legal index against a mixed port pattern
		ledPort <= 8'hA5;
		for (int y = 0; y < 8; y++)
		begin
			send(OP_SKIP_PORT_1, 4'h0, 4'h0, 4'h0);
			send(OP_SKIP_PORT_2, 4'h0, 4'h0, 4'(y));
			chk("second word", secondWord, 1'b1);
			chk("no early skip", skipNext, 1'b0);
			idle();
			chk("port skip", skipNext, !ledPort[y]);
			chk("second word end", secondWord, 1'b0);
		end
		// Index out of range never skips and is flagged
		send(OP_SKIP_PORT_1, 4'h0, 4'h0, 4'h0);
		send(OP_SKIP_PORT_2, 4'h0, 4'h0, 4'h8);
		idle();
		chk("index range skip", skipNext, 1'b0);
		// A later in-range test must leave the sticky error set
		send(OP_SKIP_PORT_1, 4'h0, 4'h0, 4'h0);
		send(OP_SKIP_PORT_2, 4'h0, 4'h0, 4'h0);
		idle();
		axiRd(OFS_STATUS);
		chk("index error flag", rd[1], 1'b1);
		axiWr(OFS_STATUS, 32'h2);
		axiRd(OFS_STATUS);
		chk("index error clear", rd, 32'h0);
		$display("test port skip done");
		// Back-to-back timer loads
		send(OP_LOAD_T1, 4'h5, 4'hA, 4'h0);
		send(OP_LOAD_T2, 4'hC, 4'h3, 4'h0);
		chk("timer one pulse", timerOneLoad, 1'b1);
		chk("timer one", timerOne, 32'hA5A5);
		idle();
		chk("timer two pulse", timerTwoLoad, 1'b1);
		chk("timer two", timerTwo, 32'h3C3C);
		chk("timer one pulse end", timerOneLoad, 1'b0);
		chk("timer one kept", timerOne, 32'hA5A5);
		axiRd(OFS_TIMER_TWO);
		chk("timer two reg", rd, 32'h3C3C);
		$display("test timer load done");
		// Disabled decoder ignores a skip that would fire
		axiWr(OFS_CTRL, 32'h0);
		carryFlag <= 1'b0;
		send(OP_SKIP_CARRY, 4'h0, 4'h0, 4'h0);
		idle();
		chk("disabled skip", skipNext, 1'b0);
		axiWr(OFS_CTRL, 32'h1);
		chk("ctrl write resp", rsp, RESP_OKAY);
		axiRd(OFS_CTRL);
		chk("ctrl write", rd, 32'h1);
		$display("test enable done");
		results();
	end
endmodule
`default_nettype wire
